// file: logic/psfi_pkg.sv
// Purpose: shared constants of the serial fault interface block
// Assumes: system clock of 10 MHz, eight-bit serial frame per device
// Notes:   times are held in their own unit, cycle counts derive from them
package psfi_pkg;

	// clock rate and unit conversions
	localparam int CLK_HZ     = 10_000_000;
	localparam int US_PER_S   = 1_000_000;
	localparam int MS_PER_S   = 1_000;
	localparam int CYC_PER_US = CLK_HZ / US_PER_S;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

	// frame layout
	localparam int FRAME_BITS  = 8;
	localparam int CHANNELS    = 4;
	localparam int CTRL_GATE   = 0;    // bits 1..4 of the frame
	localparam int CTRL_DG1    = 4;    // bit 5, long/short ground-short time
	localparam int CTRL_DG2    = 5;    // bit 6
	localparam int CTRL_DG3    = 6;    // bit 7
	localparam int CTRL_SLEEP  = 7;    // bit 8

	// reset values of the control register
	localparam logic [3:0] GATE_RST  = 4'h0;
	localparam logic [2:0] TSEL_RST  = 3'h0;
	localparam logic       SLEEP_RST = 1'b0;

	// two-bit fault codes, high bit first
	localparam logic [1:0] FC_OVERVOLT = 2'h0;
	localparam logic [1:0] FC_OPENLOAD = 2'h1;
	localparam logic [1:0] FC_OVERCURR = 2'h2;
	localparam logic [1:0] FC_GNDSHORT = 2'h3;

	// filter times in microseconds, indexed by the two low select bits
	localparam int SHORT_US_0 = 16;
	localparam int SHORT_US_1 = 4;
	localparam int SHORT_US_2 = 8;
	localparam int SHORT_US_3 = 32;
	localparam int LONG_US_0  = 120;
	localparam int LONG_US_1  = 30;
	localparam int LONG_US_2  = 60;
	localparam int LONG_US_3  = 240;
	localparam int RETRY_MS_0 = 16;    // auto-retry default, other picks scale

	// filter counts in clock cycles
	localparam int DG_W = 12;
	localparam logic [DG_W-1:0] SHORT_CYC_0 = DG_W'(SHORT_US_0 * CYC_PER_US);
	localparam logic [DG_W-1:0] SHORT_CYC_1 = DG_W'(SHORT_US_1 * CYC_PER_US);
	localparam logic [DG_W-1:0] SHORT_CYC_2 = DG_W'(SHORT_US_2 * CYC_PER_US);
	localparam logic [DG_W-1:0] SHORT_CYC_3 = DG_W'(SHORT_US_3 * CYC_PER_US);
	localparam logic [DG_W-1:0] LONG_CYC_0  = DG_W'(LONG_US_0 * CYC_PER_US);
	localparam logic [DG_W-1:0] LONG_CYC_1  = DG_W'(LONG_US_1 * CYC_PER_US);
	localparam logic [DG_W-1:0] LONG_CYC_2  = DG_W'(LONG_US_2 * CYC_PER_US);
	localparam logic [DG_W-1:0] LONG_CYC_3  = DG_W'(LONG_US_3 * CYC_PER_US);

	// auto-retry counter width, holds twice the default count
	localparam int RETRY_W       = 20;
	localparam int RETRY_DEF_CYC = RETRY_MS_0 * CYC_PER_MS;

endpackage : psfi_pkg

// file: logic/psfi_deglitch.sv
// Purpose: filter one raw fault level over a programmable number of cycles
// Assumes: raw input already synchronised to clk
// Notes:   the qualified flag drops as soon as the raw level drops
`timescale 1ns/1ps
module psfi_deglitch #(
	parameter int CW = 12
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          raw,
	input  wire logic [CW-1:0] limit,
	output logic               qual
);

	logic [CW-1:0] cnt_q;

	// count while the level stands, qualify once the limit is reached
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			qual  <= 1'b0;
		end else if (!raw) begin
			cnt_q <= '0;
			qual  <= 1'b0;
		end else if (cnt_q >= limit) begin
			qual  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

endmodule : psfi_deglitch

// file: logic/psfi_top.sv
// Purpose: serial control and fault report of a four-channel gate pre-driver
// Assumes: sclk stands still while cs_n is high; clk runs freely
// Notes:   frame logic runs on sclk, fault and control logic on clk
`timescale 1ns/1ps

module psfi_top #(
	parameter int RETRY_BASE_CYC = psfi_pkg::RETRY_DEF_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe,
	input  wire logic       fault_irq_n_in,
	output logic            fault_irq_n_out,
	output logic            fault_irq_n_oe,
	input  wire logic [3:0] parallel_gate_inputs,
	input  wire logic       retry_select,
	input  wire logic       supply_overvoltage_lockout,
	input  wire logic [3:0] openload_raw,
	input  wire logic [3:0] overcurrent_raw,
	input  wire logic [3:0] ground_short_raw,
	output logic      [3:0] gate_on,
	output logic            sleep_req,
	output logic      [2:0] timer_sel,
	output logic            irq_pending
);

	localparam int NCH = psfi_pkg::CHANNELS;
	localparam int FB  = psfi_pkg::FRAME_BITS;
	localparam int DW  = psfi_pkg::DG_W;
	localparam int RW  = psfi_pkg::RETRY_W;
	localparam int SW  = 4 * NCH + 2;    // synchronised pin inputs

	// ---------------- link side, clocked by sclk ----------------

	logic          frame_rst;
	logic          started_q;
	logic          rise_tog_q;
	logic [FB-1:0] shift_q;
	logic          sdo_q;
	logic          sdo_valid_q;
	logic [FB-1:0] fault_q;     // fault register, clk domain

	// chip select high ends the frame; the frame flags take constants
	assign frame_rst = rst | cs_n;

	// set by the first rising sclk of a frame
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			started_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
		end
	end

	// one toggle per frame that saw a rising sclk, for the clk side
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rise_tog_q <= 1'b0;
		end else if (!cs_n && !started_q) begin
			rise_tog_q <= ~rise_tog_q;
		end
	end

	// fault snapshot at the first rise, then a plain shift of sdi
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
		end else if (!cs_n) begin    // input blocked while high
			if (!started_q) begin
				shift_q <= {fault_q[FB-2:0], sdi};
			end else begin
				shift_q <= {shift_q[FB-2:0], sdi};
			end
		end
	end

	// output bit moves on falling sclk, only after a rising one
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			sdo_q       <= 1'b0;
			sdo_valid_q <= 1'b0;
		end else if (started_q) begin
			sdo_q       <= shift_q[FB-1];
			sdo_valid_q <= 1'b1;
		end
	end

	// first bit straight from the fault register, driver on while low
	assign sdo    = sdo_valid_q ? sdo_q : fault_q[FB-1];
	assign sdo_oe = ~cs_n;

	// ---------------- core side, clocked by clk ----------------

	logic          cs_s1_q, cs_s2_q, cs_s3_q;
	logic          tog_s1_q, tog_s2_q, tog_seen_q;
	logic [SW-1:0] pin_s1_q, pin_s2_q;
	logic          cs_rise, cs_fall;
	logic [3:0]    par_s;
	logic [3:0]    ol_s, oc_s, stg_s;
	logic          supply_overvoltage_lockout_s, retry_sel_s;

	// chip select and frame toggle through two flops, third for edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_s1_q  <= 1'b1;
			cs_s2_q  <= 1'b1;
			cs_s3_q  <= 1'b1;
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
		end else begin
			cs_s1_q  <= cs_n;
			cs_s2_q  <= cs_s1_q;
			cs_s3_q  <= cs_s2_q;
			tog_s1_q <= rise_tog_q;
			tog_s2_q <= tog_s1_q;
		end
	end

	// edges of the synchronised chip select, third flop holds the old level
	assign cs_rise = cs_s2_q & ~cs_s3_q;
	assign cs_fall = ~cs_s2_q & cs_s3_q;

	// remaining pins through two flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {parallel_gate_inputs, ground_short_raw,
				overcurrent_raw, openload_raw,
				supply_overvoltage_lockout, retry_select};
			pin_s2_q <= pin_s1_q;
		end
	end

	// split the synchronised pins back into their groups
	assign {par_s, stg_s, oc_s, ol_s, supply_overvoltage_lockout_s, retry_sel_s} = pin_s2_q;

	// a frame only counts once a rising sclk was seen in it; a bare chip
	// select pulse neither loads control nor clears the fault register
	logic frame_close;
	assign frame_close = cs_rise & (tog_s2_q != tog_seen_q);

	// control register loaded at the close of a clocked frame
	logic [3:0] gate_ctrl_q;
	logic [2:0] tsel_q;
	logic       sleep_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_ctrl_q <= psfi_pkg::GATE_RST;
			tsel_q      <= psfi_pkg::TSEL_RST;
			sleep_q     <= psfi_pkg::SLEEP_RST;
			tog_seen_q  <= 1'b0;
		end else if (frame_close) begin
			tog_seen_q  <= tog_s2_q;
			// shift_q is frozen: sclk stands still once cs_n is high
			gate_ctrl_q <= shift_q[psfi_pkg::CTRL_GATE +: NCH];
			tsel_q      <= {shift_q[psfi_pkg::CTRL_DG1],
				shift_q[psfi_pkg::CTRL_DG2],
				shift_q[psfi_pkg::CTRL_DG3]};
			sleep_q     <= shift_q[psfi_pkg::CTRL_SLEEP];
		end
	end

	// timer select and sleep bits of the control register straight to the pins
	assign timer_sel = tsel_q;
	assign sleep_req = sleep_q;

	// filter limits from the select bits: first bit long or short
	logic [DW-1:0] short_lim, long_lim, stg_lim;
	logic [RW-1:0] retry_lim;

	always_comb begin
		case (tsel_q[1:0])
			2'h0: begin
				short_lim = psfi_pkg::SHORT_CYC_0;
				long_lim  = psfi_pkg::LONG_CYC_0;
				retry_lim = RW'(RETRY_BASE_CYC);
			end
			2'h1: begin
				short_lim = psfi_pkg::SHORT_CYC_1;
				long_lim  = psfi_pkg::LONG_CYC_1;
				retry_lim = RW'(RETRY_BASE_CYC / 4);
			end
			2'h2: begin
				short_lim = psfi_pkg::SHORT_CYC_2;
				long_lim  = psfi_pkg::LONG_CYC_2;
				retry_lim = RW'(RETRY_BASE_CYC / 2);
			end
			default: begin
				short_lim = psfi_pkg::SHORT_CYC_3;
				long_lim  = psfi_pkg::LONG_CYC_3;
				retry_lim = RW'(RETRY_BASE_CYC * 2);
			end
		endcase
		stg_lim = tsel_q[2] ? long_lim : short_lim;
	end

	// one filter per channel and fault type: open, over-current, short
	logic [3*NCH-1:0] raw_all, qual_all;
	logic [NCH-1:0]   ol_q, oc_q, stg_q;

	// open load is only watched while the gate is off
	assign raw_all = {stg_s, oc_s, ol_s & ~gate_on};
	assign {stg_q, oc_q, ol_q} = qual_all;

	for (genvar i = 0; i < 3 * NCH; i++) begin : g_filt
		psfi_deglitch #(
			.CW (DW)
		) u_filt (
			.clk   (clk),
			.rst   (rst),
			.raw   (raw_all[i]),
			.limit ((i < 2 * NCH) ? long_lim : stg_lim),
			.qual  (qual_all[i])
		);
	end

	// fault register: latches while chip select is high
	logic [NCH-1:0] flag_q;
	logic [NCH-1:0] hit;
	logic [FB-1:0]  code_now;
	logic           any_fault;

	// worst fault of each channel wins: short, over-current, open
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			hit[c] = stg_q[c] | oc_q[c] | ol_q[c];
			if (stg_q[c]) begin
				code_now[2*c +: 2] = psfi_pkg::FC_GNDSHORT;
			end else if (oc_q[c]) begin
				code_now[2*c +: 2] = psfi_pkg::FC_OVERCURR;
			end else if (ol_q[c]) begin
				code_now[2*c +: 2] = psfi_pkg::FC_OPENLOAD;
			end else begin
				code_now[2*c +: 2] = psfi_pkg::FC_OVERVOLT;
			end
		end
		any_fault = (|hit) | supply_overvoltage_lockout_s;
	end

	// the sclk side snapshots fault_q at its first rising edge, so the
	// register must not move once chip select low has been synchronised
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_q <= '0;
			flag_q  <= '0;
		end else if (cs_s2_q) begin    // frozen while a frame reads it
			for (int c = 0; c < NCH; c++) begin
				if (hit[c]) begin    // set wins over the clear
					fault_q[2*c +: 2] <= code_now[2*c +: 2];
					flag_q[c]         <= 1'b1;
				end else if (frame_close) begin
					fault_q[2*c +: 2] <= psfi_pkg::FC_OVERVOLT;
					flag_q[c]         <= 1'b0;
				end
			end
		end
	end

	// latched interrupt, set by any fault, refreshed at a falling chip select while no fault is present
	logic irq_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (any_fault) begin
			irq_q <= 1'b1;
		end else if (cs_fall) begin
			irq_q <= |flag_q;
		end
	end

	// open drain: drive low only while a fault is latched
	assign fault_irq_n_out = 1'b0;
	assign fault_irq_n_oe  = irq_q;
	assign irq_pending     = irq_q;

	// auto-retry: over-current or short blocks a gate for a while
	logic [NCH-1:0] blocked_q;
	logic [RW-1:0]  retry_cnt_q;
	logic [NCH-1:0] trip;

	assign trip = stg_q | oc_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blocked_q   <= '0;
			retry_cnt_q <= '0;
		end else if (|trip) begin
			blocked_q   <= blocked_q | trip;
			retry_cnt_q <= retry_lim;
		end else if (!retry_sel_s && (|blocked_q)) begin
			if (retry_cnt_q == '0) begin
				blocked_q <= '0;
			end else begin
				retry_cnt_q <= retry_cnt_q - RW'(1);
			end
		end else if (retry_sel_s && cs_rise) begin
			blocked_q <= '0;    // latched off until chip select next rises
		end
	end

	// gate drive: serial bit or parallel input, cut by sleep or faults
	logic [NCH-1:0] gate_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_q <= '0;
		end else if (sleep_q || supply_overvoltage_lockout_s) begin
			gate_q <= '0;
		end else begin
			gate_q <= (gate_ctrl_q | par_s) & ~blocked_q;
		end
	end

	assign gate_on = gate_q;

endmodule : psfi_top

// file: verif/psfi_asserts.sv
// Purpose: port checks of the serial fault interface
// Assumes: frames keep chip select low for at least four clk cycles
// Notes:   bound to psfi_top from the bench top file
`timescale 1ns/1ps
module psfi_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       cs_n,
	input wire logic       sdo_oe,
	input wire logic       fault_irq_n_out,
	input wire logic       fault_irq_n_oe,
	input wire logic       supply_overvoltage_lockout,
	input wire logic       sleep_req,
	input wire logic [2:0] timer_sel,
	input wire logic       irq_pending
);
	logic [2:0] hi_cnt_q;

	// clk cycles since chip select went high, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			hi_cnt_q <= 3'h0;
		else if (!cs_n)
			hi_cnt_q <= 3'h0;
		else if (hi_cnt_q != 3'h7)
			hi_cnt_q <= hi_cnt_q + 3'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_oe_tracks_cs: assert property (sdo_oe == !cs_n)
		else $error("serial output enable differs from chip select");
	chk_irq_pair: assert property (irq_pending == fault_irq_n_oe)
		else $error("pending flag differs from interrupt enable");
	chk_irq_out_low: assert property (fault_irq_n_oe |-> !fault_irq_n_out)
		else $error("interrupt driven but not low");
	chk_ctrl_window: assert property (
		$changed(timer_sel) || $changed(sleep_req)
		|-> cs_n && hi_cnt_q inside {[3'h1:3'h5]})
		else $error("control changed outside frame close");
	chk_reset_defaults: assert property ($fell(rst) |->
		timer_sel == 3'h0 && !sleep_req && !irq_pending)
		else $error("control not at default after reset");
	chk_irq_release_cs: assert property (
		$fell(irq_pending) |-> !cs_n && !$past(cs_n, 2))
		else $error("interrupt released without chip select low");
	chk_irq_hold_high: assert property (
		irq_pending && cs_n |=> irq_pending)
		else $error("interrupt released while chip select high");
	chk_ov_raises_irq: assert property (
		supply_overvoltage_lockout |-> ##[1:5] irq_pending)
		else $error("overvoltage did not raise interrupt");

	// main scenarios reached
	cov_frame: cover property ($fell(cs_n));
	cov_irq: cover property ($rose(irq_pending));
	cov_timer: cover property ($changed(timer_sel));
endmodule : psfi_asserts

// file: verif/psfi_host.sv
// Purpose: host side of the serial link, drives frames and reads faults
// Assumes: serial clock of 30 ns period, still between frames
// Notes:   data line falls to its pull-down level outside bit times
`timescale 1ns/1ps
module psfi_host (
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	// one frame of n bits, d[n-1] first, q gathers what comes out
	// hi leaves sclk high as chip select falls; the offset keeps the link
	// edges away from the system clock edges
	task automatic frame(input logic [15:0] d, input int n,
		input logic hi, output logic [15:0] q);
		q = 16'h0000;
		sclk = hi;
		#7 cs_n = 1'b0;
		#150 sclk = 1'b0; // a clock left high must not shift
		#150;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = d[i];
			#15 q = {q[14:0], sdo};
			sclk = 1'b1;
			#15 sclk = 1'b0;
		end
		sdi = 1'b0;
		#120 cs_n = 1'b1;
		#450;
	endtask : frame
endmodule : psfi_host

// file: verif/prefet_serial_fault_interface_bench.sv
// Purpose: self-checking bench of the serial fault interface
// Assumes: retry base shortened, parallel and on-state inputs idle
// Notes:   host model drives the link, bench drives fault levels
`timescale 1ns/1ps
module prefet_serial_fault_interface_bench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sclk, cs_n, sdi, sdo, sdo_oe, irq_out, irq_oe, irq_in;
	logic        ov = 1'b0;
	logic [3:0]  open_raw = 4'h0;
	logic [3:0]  gnd_raw = 4'h0;
	logic [3:0]  gate_on;
	logic [2:0]  timer_sel;
	logic        sleep_req, irq_pending;
	logic [15:0] q;
	int          errors, compares, cyc;

	always #50 clk = ~clk;
	// open-drain wire with pull-up
	assign irq_in = irq_oe ? irq_out : 1'b1;

	psfi_top #(.RETRY_BASE_CYC(400)) u_dut (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.fault_irq_n_in(irq_in), .fault_irq_n_out(irq_out),
		.fault_irq_n_oe(irq_oe), .parallel_gate_inputs(4'h0),
		.retry_select(1'b0), .supply_overvoltage_lockout(ov),
		.openload_raw(open_raw), .overcurrent_raw(4'h0),
		.ground_short_raw(gnd_raw), .gate_on(gate_on),
		.sleep_req(sleep_req), .timer_sel(timer_sel),
		.irq_pending(irq_pending)
	);
	psfi_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// frame then wait for closure in the clk domain
	task automatic frm(input logic [15:0] d, input int n);
		u_host.frame(d, n, 1'b0, q);
		repeat (6) @(posedge clk);
	endtask : frm

	task automatic t_timers();
		for (int k = 0; k < 8; k++) begin
			frm({8'h00, k == 7, k[0], k[1], k[2], 4'h5}, 8);
			chk(timer_sel, k[2:0]);
			chk(gate_on, (k == 7) ? 4'h0 : 4'h5);
			chk(sleep_req, k == 7);
		end
	endtask : t_timers

	task automatic t_open();
		frm(16'h0040, 8);
		@(posedge clk) open_raw <= 4'h2;
		gnd_raw <= 4'h8;
		repeat (400) @(posedge clk);
		chk(irq_pending, 1'b1);
		open_raw <= 4'h0;
		gnd_raw <= 4'h0;
		// let the auto-retry hold of channel four run out
		repeat (120) @(posedge clk);
		frm(16'h0040, 8);
		chk(q, 16'h00C4);
		frm(16'h0040, 8);
		chk(q, 16'h0000);
		chk(irq_pending, 1'b0);
	endtask : t_open

	task automatic t_supply_overvoltage_lockout();
		@(posedge clk) ov <= 1'b1;
		repeat (6) @(posedge clk);
		chk(irq_oe, 1'b1);
		ov <= 1'b0;
		frm(16'h0040, 8);
		chk(q, 16'h0000);
		chk(irq_pending, 1'b0);
	endtask : t_supply_overvoltage_lockout

	task automatic t_short();
		frm(16'h000A, 8);
		frm(16'h0000, 0);
		chk(gate_on, 4'hA);
		frm(16'h000F, 4);
		chk({timer_sel, gate_on}, 7'h0F);
	endtask : t_short

	task automatic t_chain();
		u_host.frame(16'hC325, 16, 1'b1, q);
		repeat (6) @(posedge clk);
		chk(q, 16'h00C3);
		chk({sleep_req, timer_sel, gate_on}, 8'h25);
	endtask : t_chain

	// cycle ceiling against hangs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			end_sim();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({sleep_req, timer_sel, gate_on}, 8'h00);
		chk({irq_pending, sdo_oe}, 2'h0);
		t_timers();
		t_open();
		t_supply_overvoltage_lockout();
		t_short();
		t_chain();
		end_sim();
	end
endmodule : prefet_serial_fault_interface_bench

bind psfi_top psfi_asserts u_chk (
	.clk(clk), .rst(rst), .cs_n(cs_n), .sdo_oe(sdo_oe),
	.fault_irq_n_out(fault_irq_n_out), .fault_irq_n_oe(fault_irq_n_oe),
	.supply_overvoltage_lockout(supply_overvoltage_lockout),
	.sleep_req(sleep_req), .timer_sel(timer_sel),
	.irq_pending(irq_pending)
);
